// >>> rtl/emb_event_pkg.sv
// Package: register map, field positions and reset values of the embedded event block
package emb_event_pkg;
  // Register offsets (byte addresses = 4 * index)
  localparam logic [7:0] IDX_PAGE_SEL = 8'h02;
  localparam logic [7:0] IDX_HIGH_ROUTE = 8'h10;
  localparam logic [7:0] IDX_EVENT_STATUS = 8'h12;
  localparam logic [7:0] IDX_LOW_STATUS = 8'h13;
  localparam logic [7:0] IDX_HIGH_STATUS = 8'h14;
  localparam logic [7:0] IDX_PAGE_ACCESS = 8'h17;
  localparam logic [7:0] IDX_BATCH_CFG = 8'h44;
  localparam logic [7:0] IDX_LOW_ENABLE = 8'h46;
  localparam logic [7:0] IDX_ROUTE_CFG = 8'h5F;
  localparam logic [7:0] IDX_PAGE_DATA = 8'h60;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h70;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h71;
  // Field positions
  localparam int LC_BIT = 7;
  localparam int SIGMOT_BIT = 5;
  localparam int TILT_BIT = 4;
  localparam int STEP_BIT = 3;
  localparam int LATCH_BIT = 7;
  localparam int PWRITE_BIT = 6;
  localparam int PREAD_BIT = 5;
  localparam int BATCH_BIT = 6;
  localparam int GROUTE_BIT = 4;
  // Reset values and masks
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] EVT_STATUS_MASK = 8'hB8;
  localparam logic [7:0] PAGE_ACCESS_MASK = 8'hE0;
  localparam logic [7:0] BATCH_MASK = 8'h40;
  localparam logic [7:0] PAGE_SEL_MASK = 8'h0F;
  localparam logic [7:0] ROUTE_CFG_MASK = 8'h10;
  localparam logic [2:0] IRQ_SRC_MASK = 3'h7;
  localparam int PAGES = 16;
  localparam int MACHINES = 16;
  localparam int IRQ_SRCS = 3;
endpackage : emb_event_pkg

// >>> rtl/emb_event_regs.sv
// Embedded event status, routing, page access and enable registers on Avalon-MM
`timescale 1ns/10ps
`default_nettype none
//----------------------------------------------------------------------
// Function
// RULE1: Second interrupt pin drives OR of all routed events.
// RULE2: Register 10h holds routing enables for machines 9-16, reset zero.
// RULE3: Machine routing applies only while global route bit at 5Fh set.
// RULE4: Status 12h top bit reports long-counter timeout.
// RULE5: Status 12h reports significant motion bit.
// RULE6: Status 12h reports tilt bit.
// RULE7: Status 12h reports step bit; bits 0-2 and 6 read zero.
// RULE8: Register 13h reports machines 1-8 status, machine 8 on top.
// RULE9: Register 14h reports machines 9-16 status, machine 16 on top.
// RULE10: Top bit of 17h selects latched event requests, reset zero.
// RULE11: Page writes accepted only while page write enable set.
// RULE12: Page reads return contents only while page read enable set.
// RULE13: Page targeted by four-bit select field at 02h.
// RULE14: Host writes zero to reserved bits of 17h and 44h.
// RULE15: Bit at 44h enables step-count batching into FIFO, reset zero.
// RULE16: Register 46h enables machines 1-8, machine 8 on top.
// RULE17: Embedded status register is read-only to the host.
// RULE18: Latched status holds until read; unlatched follows live condition.
//----------------------------------------------------------------------
module emb_event_regs
  import emb_event_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Avalon-MM slave
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  // Event sources, same clock domain
  input wire logic long_counter_timeout_i,
  input wire logic significant_motion_i,
  input wire logic tilt_event_i,
  input wire logic step_detect_i,
  input wire logic [MACHINES-1:0] machine_event_i,
  // Pins and controls
  output logic second_interrupt_pin_o,
  output logic irq_o,
  output logic [7:0] machine_low_enable_o,
  output logic step_count_batch_enable_o
);

  //--------------------------------------------------------------------
  // Bus decode
  //--------------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } bus_state_t;

  bus_state_t bus_state_r;
  logic [7:0] idx;
  logic word_ok;
  logic wr_stb;
  logic rd_stb;
  logic lane0;
  logic [7:0] wbyte;

  assign idx = avs_address_i[9:2];
  assign word_ok = (avs_address_i[1:0] == 2'h0);
  assign lane0 = avs_byteenable_i[0];
  assign wbyte = avs_writedata_i[7:0];
  // Each request is taken once, in the idle cycle; acked one cycle later
  assign wr_stb = (bus_state_r == BUS_IDLE) && avs_write_i && word_ok && lane0;
  assign rd_stb = (bus_state_r == BUS_IDLE) && avs_read_i && word_ok;

  logic hit_route;
  logic hit_evt;
  logic hit_low;
  logic hit_high;
  logic hit_page_acc;
  logic hit_batch;
  logic hit_enable;
  logic hit_route_cfg;
  logic hit_page_sel;
  logic hit_page_data;
  logic hit_irq_st;
  logic hit_irq_mask;
  logic hit_any;

  assign hit_route = (idx == IDX_HIGH_ROUTE);
  assign hit_evt = (idx == IDX_EVENT_STATUS);
  assign hit_low = (idx == IDX_LOW_STATUS);
  assign hit_high = (idx == IDX_HIGH_STATUS);
  assign hit_page_acc = (idx == IDX_PAGE_ACCESS);
  assign hit_batch = (idx == IDX_BATCH_CFG);
  assign hit_enable = (idx == IDX_LOW_ENABLE);
  assign hit_route_cfg = (idx == IDX_ROUTE_CFG);
  assign hit_page_sel = (idx == IDX_PAGE_SEL);
  assign hit_page_data = (idx == IDX_PAGE_DATA);
  assign hit_irq_st = (idx == IDX_IRQ_STATUS);
  assign hit_irq_mask = (idx == IDX_IRQ_MASK);
  assign hit_any = hit_route | hit_evt | hit_low | hit_high | hit_page_acc | hit_batch
                 | hit_enable | hit_route_cfg | hit_page_sel | hit_page_data
                 | hit_irq_st | hit_irq_mask;

  //--------------------------------------------------------------------
  // Control registers
  //--------------------------------------------------------------------
  logic [7:0] route_r;
  logic [7:0] page_acc_r;
  logic [7:0] batch_r;
  logic [7:0] enable_r;
  logic [7:0] route_cfg_r;
  logic [7:0] page_sel_r;
  logic [IRQ_SRCS-1:0] irq_mask_r;
  logic [7:0] page_mem_r [PAGES];
  logic wr_route;
  logic wr_page_acc;
  logic wr_batch;
  logic wr_enable;
  logic wr_route_cfg;
  logic wr_page_sel;
  logic wr_irq_mask;

  // One strobe per register keeps each flop block to a single load condition
  assign wr_route = wr_stb && hit_route;
  assign wr_page_acc = wr_stb && hit_page_acc;
  assign wr_batch = wr_stb && hit_batch;
  assign wr_enable = wr_stb && hit_enable;
  assign wr_route_cfg = wr_stb && hit_route_cfg;
  assign wr_page_sel = wr_stb && hit_page_sel;
  assign wr_irq_mask = wr_stb && hit_irq_mask;

  // RULE2: machine routing write
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      route_r <= RST_BYTE;
    end else if (wr_route) begin
      route_r <= wbyte;
    end
  end

  // RULE10: latch mode and page enables; RULE14: reserved bits kept zero
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      page_acc_r <= RST_BYTE;
    end else if (wr_page_acc) begin
      page_acc_r <= wbyte & PAGE_ACCESS_MASK;
    end
  end

  // RULE15: batching enable; RULE14: reserved bits kept zero
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      batch_r <= RST_BYTE;
    end else if (wr_batch) begin
      batch_r <= wbyte & BATCH_MASK;
    end
  end

  // RULE16: machine enables
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enable_r <= RST_BYTE;
    end else if (wr_enable) begin
      enable_r <= wbyte;
    end
  end

  // Only the global route bit is kept; other routes of this register are not built here
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      route_cfg_r <= RST_BYTE;
    end else if (wr_route_cfg) begin
      route_cfg_r <= wbyte & ROUTE_CFG_MASK;
    end
  end

  // RULE13: page select field
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      page_sel_r <= RST_BYTE;
    end else if (wr_page_sel) begin
      page_sel_r <= wbyte & PAGE_SEL_MASK;
    end
  end

  // Block interrupt mask, one bit per status group
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_mask_r <= '0;
    end else if (wr_irq_mask) begin
      irq_mask_r <= wbyte[IRQ_SRCS-1:0];
    end
  end

  // Feature page storage, one byte per page for this block
  logic [3:0] page_idx;
  logic page_wr_ok;
  assign page_idx = page_sel_r[3:0];
  // RULE11: page write gate
  assign page_wr_ok = wr_stb && hit_page_data && page_acc_r[PWRITE_BIT];

  genvar gp;
  generate
    for (gp = 0; gp < PAGES; gp++) begin : g_page
      always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          page_mem_r[gp] <= RST_BYTE;
        end else if (page_wr_ok && (page_idx == 4'(gp))) begin
          page_mem_r[gp] <= wbyte;
        end
      end
    end
  endgenerate

  //--------------------------------------------------------------------
  // Event status
  //--------------------------------------------------------------------
  logic latch_mode;
  logic [7:0] evt_live;
  logic [7:0] evt_st_r;
  logic [7:0] low_st_r;
  logic [7:0] high_st_r;
  logic [7:0] evt_st_nxt;
  logic [7:0] low_st_nxt;
  logic [7:0] high_st_nxt;
  logic rd_evt;
  logic rd_low;
  logic rd_high;

  assign latch_mode = page_acc_r[LATCH_BIT];
  // RULE4: long counter; RULE5: motion; RULE6: tilt; RULE7: step, others zero
  assign evt_live = {long_counter_timeout_i, 1'b0, significant_motion_i, tilt_event_i,
                     step_detect_i, 3'b000};
  assign rd_evt = rd_stb && hit_evt;
  assign rd_low = rd_stb && hit_low;
  assign rd_high = rd_stb && hit_high;
  // RULE18: latched bits clear on read, a new event wins over the clear
  assign evt_st_nxt = latch_mode ? ((rd_evt ? 8'h00 : evt_st_r) | evt_live) : evt_live;
  // RULE8: machines 1-8
  assign low_st_nxt = latch_mode ? ((rd_low ? 8'h00 : low_st_r) | machine_event_i[7:0])
                                 : machine_event_i[7:0];
  // RULE9: machines 9-16
  assign high_st_nxt = latch_mode ? ((rd_high ? 8'h00 : high_st_r) | machine_event_i[15:8])
                                  : machine_event_i[15:8];

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      evt_st_r <= RST_BYTE;
      low_st_r <= RST_BYTE;
      high_st_r <= RST_BYTE;
    end else begin
      // RULE17: no bus write path into status
      evt_st_r <= evt_st_nxt & EVT_STATUS_MASK;
      low_st_r <= low_st_nxt;
      high_st_r <= high_st_nxt;
    end
  end

  //--------------------------------------------------------------------
  // Second interrupt pin
  //--------------------------------------------------------------------
  logic pin_nxt;
  logic pin_r;
  // RULE1: OR of routed events; RULE3: global route gate
  assign pin_nxt = route_cfg_r[GROUTE_BIT] && (|(high_st_nxt & route_r));

  //--------------------------------------------------------------------
  // Block interrupt: sticky status, mask, write-one-to-clear
  //--------------------------------------------------------------------
  logic [IRQ_SRCS-1:0] irq_ev;
  logic [IRQ_SRCS-1:0] irq_st_r;
  logic [IRQ_SRCS-1:0] irq_clr;
  logic irq_r;

  assign irq_ev = {|high_st_nxt, |low_st_nxt, |evt_st_nxt};
  assign irq_clr = (wr_stb && hit_irq_st) ? wbyte[IRQ_SRCS-1:0] : '0;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_st_r <= '0;
      irq_r <= 1'b0;
      pin_r <= 1'b0;
    end else begin
      irq_st_r <= ((irq_st_r & ~irq_clr) | irq_ev) & IRQ_SRC_MASK;
      irq_r <= |(((irq_st_r & ~irq_clr) | irq_ev) & irq_mask_r);
      pin_r <= pin_nxt;
    end
  end

  //--------------------------------------------------------------------
  // Read mux and handshake
  //--------------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_route) begin
      rd_byte = route_r;
    end else if (hit_evt) begin
      rd_byte = evt_st_r;
    end else if (hit_low) begin
      rd_byte = low_st_r;
    end else if (hit_high) begin
      rd_byte = high_st_r;
    end else if (hit_page_acc) begin
      rd_byte = page_acc_r;
    end else if (hit_batch) begin
      rd_byte = batch_r;
    end else if (hit_enable) begin
      rd_byte = enable_r;
    end else if (hit_route_cfg) begin
      rd_byte = route_cfg_r;
    end else if (hit_page_sel) begin
      rd_byte = page_sel_r;
    end else if (hit_page_data) begin
      // RULE12: page read gate
      rd_byte = page_acc_r[PREAD_BIT] ? page_mem_r[page_idx] : 8'h00;
    end else if (hit_irq_st) begin
      rd_byte = {5'h00, irq_st_r};
    end else if (hit_irq_mask) begin
      rd_byte = {5'h00, irq_mask_r};
    end
  end

  logic [31:0] rdata_r;
  logic [1:0] resp_r;
  logic take;
  assign take = (bus_state_r == BUS_IDLE) && (avs_read_i || avs_write_i);

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_state_r <= BUS_IDLE;
      rdata_r <= 32'h0000_0000;
      resp_r <= 2'b00;
    end else begin
      case (bus_state_r)
        BUS_IDLE: begin
          if (take) begin
            bus_state_r <= BUS_ACK;
            rdata_r <= {24'h000000, ((avs_read_i && word_ok) ? rd_byte : 8'h00)};
            // Unmapped or misaligned access answers SLAVEERROR
            resp_r <= (hit_any && word_ok) ? 2'b00 : 2'b10;
          end
        end
        BUS_ACK: begin
          bus_state_r <= BUS_IDLE;
        end
        default: begin
          bus_state_r <= BUS_IDLE;
        end
      endcase
    end
  end

  // Waitrequest is low only in the ack cycle, so the master needs no extra state
  logic wait_r;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !take;
    end
  end

  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign avs_response_o = resp_r;
  assign second_interrupt_pin_o = pin_r;
  assign irq_o = irq_r;
  assign machine_low_enable_o = enable_r;
  assign step_count_batch_enable_o = batch_r[BATCH_BIT];

endmodule // emb_event_regs
`default_nettype wire

// >>> tb/event_source_model.sv
// Event source model: drives the sensor-side event levels on command
`timescale 1ns/10ps
`default_nettype none
module event_source_model (
  // Clock, reset and command from the bench
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [19:0] cmd_i,
  // Levels: timeout, motion, tilt, step, machines 16 down to 1
  output logic [19:0] event_o
);
  // --------------------------------
  // Event drive
  // --------------------------------
  // Levels move only just after an edge, as the sensor logic does
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      event_o <= 20'h00000;
    end else begin
      event_o <= cmd_i;
    end
  end
endmodule // event_source_model
`default_nettype wire

// >>> tb/emb_event_regs_monitor.sv
// Port-level checker for the embedded event register block
`timescale 1ns/10ps
`default_nettype none
module emb_event_regs_monitor
  import emb_event_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Avalon-MM slave
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [1:0] avs_response_o,
  // Events and pins
  input wire logic long_counter_timeout_i,
  input wire logic significant_motion_i,
  input wire logic tilt_event_i,
  input wire logic step_detect_i,
  input wire logic [MACHINES-1:0] machine_event_i,
  input wire logic second_interrupt_pin_o,
  input wire logic irq_o,
  input wire logic [7:0] machine_low_enable_o,
  input wire logic step_count_batch_enable_o
);
  // --------------------------------
  // Helpers and sequences
  // --------------------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  wire logic take = (avs_read_i || avs_write_i) && avs_waitrequest_o;
  // A host write also counts as a cause, since routing and masks can expose held status
  wire logic cause = long_counter_timeout_i || significant_motion_i || tilt_event_i
    || step_detect_i || (|machine_event_i) || avs_write_i;
  sequence wr_to(logic [7:0] idx);
    take && avs_write_i && avs_byteenable_i[0] && avs_address_i == {idx, 2'b00};
  endsequence
  sequence rd_of(logic [7:0] idx);
    take && avs_read_i && avs_address_i == {idx, 2'b00};
  endsequence
  sequence one_cycle_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  // --------------------------------
  // Assertions
  // --------------------------------
  ack_one_cycle_a:
    assert property (take |=> one_cycle_ack) else $error("ack not one cycle");
  ack_cause_a:
    assert property ($fell(avs_waitrequest_o) |-> $past(take)) else $error("ack without request");
  low_enable_a:
    assert property (wr_to(IDX_LOW_ENABLE) |=> machine_low_enable_o == $past(avs_writedata_i[7:0]))
    else $error("enable write lost");
  enable_hold_a:
    assert property ($changed(machine_low_enable_o) |-> $past(avs_write_i && avs_waitrequest_o))
    else $error("enable moved without write");
  batch_write_a:
    assert property (wr_to(IDX_BATCH_CFG) |=>
      step_count_batch_enable_o == $past(avs_writedata_i[BATCH_BIT])) else $error("batch bit lost");
  status_zero_a:
    assert property (rd_of(IDX_EVENT_STATUS) |=> (avs_readdata_o[7:0] & ~EVT_STATUS_MASK) == 8'h00)
    else $error("status reserved bit set");
  bad_addr_a:
    assert property (take && avs_address_i[1:0] != 2'b00 |=>
      avs_response_o == 2'b10 && avs_readdata_o == 32'h00000000) else $error("misaligned accepted");
  pin_cause_a:
    assert property ($rose(second_interrupt_pin_o) |-> $past(cause) || $past(cause, 2))
    else $error("pin rose without cause");
  irq_cause_a:
    assert property ($rose(irq_o) |-> $past(cause) || $past(cause, 2) || $past(cause, 3))
    else $error("irq rose without cause");
endmodule // emb_event_regs_monitor
`default_nettype wire

// >>> tb/emb_event_regs_tb.sv
// Self-checking bench for the embedded event register block
`timescale 1ns/10ps
`default_nettype none
module emb_event_regs_tb
  import emb_event_pkg::*;
();
  typedef struct packed {logic [7:0] idx; logic [7:0] d; logic [7:0] e;} row_t;
  logic ref_clk_i, resetn_i, rd, wr, wreq, pin, irq, batch;
  logic [9:0] addr;
  logic [1:0] off, resp;
  logic [31:0] wdata, rdata;
  logic [7:0] low_en, got;
  logic [19:0] cmd, ev;
  int n_fail, n_tests;
  // Reserved bits are written as zero; the status write must not stick
  row_t rows [7] = '{'{IDX_EVENT_STATUS, 8'hFF, 8'h00}, '{IDX_HIGH_ROUTE, 8'hC3, 8'hC3},
    '{IDX_PAGE_ACCESS, 8'hE0, 8'hE0}, '{IDX_BATCH_CFG, 8'h40, 8'h40},
    '{IDX_LOW_ENABLE, 8'hA5, 8'hA5}, '{IDX_PAGE_SEL, 8'h05, 8'h05},
    '{IDX_ROUTE_CFG, 8'h10, 8'h10}};
  emb_event_regs DUT (.ref_clk_i, .resetn_i, .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .avs_response_o(resp),
    .long_counter_timeout_i(ev[19]), .significant_motion_i(ev[18]), .tilt_event_i(ev[17]),
    .step_detect_i(ev[16]), .machine_event_i(ev[15:0]), .second_interrupt_pin_o(pin),
    .irq_o(irq), .machine_low_enable_o(low_en), .step_count_batch_enable_o(batch));
  event_source_model src (.ref_clk_i, .resetn_i, .cmd_i(cmd), .event_o(ev));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // --------------------------------
  // Bus and check tasks
  // --------------------------------
  task automatic give_verdict();
    if (n_fail == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Starts one edge late so a release and the next request never share a time step
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int i;
    @(posedge ref_clk_i);
    rd <= !w;
    wr <= w;
    addr <= {idx, off};
    wdata <= {24'h000000, d};
    i = 0;
    do begin
      @(posedge ref_clk_i);
      i++;
    end while (wreq !== 1'b0 && i < 50);
    if (i >= 50) begin
      chk(8'hEE, 8'h00);
      give_verdict();
    end
    got = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(got, e);
  endtask
  task automatic wt();
    repeat (3) @(posedge ref_clk_i);
  endtask
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    resetn_i = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 10'h000;
    off = 2'h0;
    wdata = 32'h00000000;
    cmd = 20'h00000;
    n_fail = 0;
    n_tests = 0;
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    foreach (rows[k]) begin
      rdc(rows[k].idx, RST_BYTE);
      bus(1'b1, rows[k].idx, rows[k].d);
      rdc(rows[k].idx, rows[k].e);
    end
    chk(low_en, 8'hA5);
    chk({7'h00, batch}, 8'h01);
    bus(1'b1, IDX_PAGE_DATA, 8'h5A);
    rdc(IDX_PAGE_DATA, 8'h5A);
    bus(1'b1, IDX_PAGE_ACCESS, 8'h20);
    bus(1'b1, IDX_PAGE_DATA, 8'h33);
    rdc(IDX_PAGE_DATA, 8'h5A);
    bus(1'b1, IDX_PAGE_ACCESS, 8'h40);
    bus(1'b1, IDX_PAGE_SEL, 8'h06);
    bus(1'b1, IDX_PAGE_DATA, 8'h77);
    rdc(IDX_PAGE_DATA, 8'h00);
    bus(1'b1, IDX_PAGE_ACCESS, 8'h20);
    rdc(IDX_PAGE_DATA, 8'h77);
    bus(1'b1, IDX_PAGE_SEL, 8'h05);
    rdc(IDX_PAGE_DATA, 8'h5A);
    bus(1'b1, IDX_PAGE_ACCESS, 8'h00);
    cmd <= 20'hFA55A;
    wt();
    rdc(IDX_EVENT_STATUS, 8'hB8);
    rdc(IDX_LOW_STATUS, 8'h5A);
    rdc(IDX_HIGH_STATUS, 8'hA5);
    bus(1'b1, IDX_ROUTE_CFG, 8'h00);
    wt();
    chk({7'h00, pin}, 8'h00);
    bus(1'b1, IDX_ROUTE_CFG, 8'h10);
    wt();
    chk({7'h00, pin}, 8'h01);
    cmd <= 20'h00400;
    wt();
    chk({7'h00, pin}, 8'h00);
    cmd <= 20'h00000;
    wt();
    rdc(IDX_EVENT_STATUS, 8'h00);
    bus(1'b1, IDX_PAGE_ACCESS, 8'h80);
    cmd <= 20'h20000;
    @(posedge ref_clk_i);
    cmd <= 20'h00000;
    wt();
    rdc(IDX_EVENT_STATUS, 8'h10);
    rdc(IDX_EVENT_STATUS, 8'h00);
    rdc(IDX_IRQ_STATUS, 8'h07);
    bus(1'b1, IDX_IRQ_MASK, 8'h00);
    wt();
    chk({7'h00, irq}, 8'h00);
    bus(1'b1, IDX_IRQ_MASK, 8'h07);
    wt();
    chk({7'h00, irq}, 8'h01);
    bus(1'b1, IDX_IRQ_STATUS, 8'h07);
    wt();
    rdc(IDX_IRQ_STATUS, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rdc(8'hFF, 8'h00);
    chk({6'h00, resp}, 8'h02);
    off = 2'h1;
    bus(1'b1, IDX_LOW_ENABLE, 8'h00);
    rdc(IDX_LOW_ENABLE, 8'h00);
    chk({6'h00, resp}, 8'h02);
    off = 2'h0;
    rdc(IDX_LOW_ENABLE, 8'hA5);
    resetn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rdc(IDX_HIGH_ROUTE, 8'h00);
    chk(low_en, 8'h00);
    give_verdict();
  end
endmodule // emb_event_regs_tb
bind emb_event_regs emb_event_regs_monitor mon (.ref_clk_i, .resetn_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
  .avs_waitrequest_o, .avs_response_o, .long_counter_timeout_i, .significant_motion_i,
  .tilt_event_i, .step_detect_i, .machine_event_i, .second_interrupt_pin_o, .irq_o,
  .machine_low_enable_o, .step_count_batch_enable_o);
`default_nettype wire
